// ---- cspr_pkg.sv ----
// Constants and types shared by the card socket status and power registers
package cspr_pkg;

  // Byte register offsets on the socket register port
  localparam logic [11:0] CSPR_ADDR_ID = 12'h800;
  localparam logic [11:0] CSPR_ADDR_STATUS = 12'h801;
  localparam logic [11:0] CSPR_ADDR_POWER = 12'h802;

  // Identification register: reset value, fixed type bits, writable bits
  localparam logic [7:0] CSPR_ID_RESET = 8'h84;
  localparam logic [7:0] CSPR_ID_FIXED = 8'h80;
  localparam logic [7:0] CSPR_ID_WR_MASK = 8'h3F;
  localparam logic [3:0] CSPR_REV_LEGACY = 4'h2;

  // Status register bit positions
  localparam int CSPR_ST_RSVD_BIT = 7;
  localparam int CSPR_ST_POWER_BIT = 6;
  localparam int CSPR_ST_READY_BIT = 5;
  localparam int CSPR_ST_WP_BIT = 4;
  localparam int CSPR_ST_CD2_BIT = 3;
  localparam int CSPR_ST_CD1_BIT = 2;
  localparam int CSPR_ST_BVD2_BIT = 1;
  localparam int CSPR_ST_BVD1_BIT = 0;

  // Power control register fields
  localparam logic [7:0] CSPR_PWR_RESET = 8'h00;
  localparam int CSPR_PWR_GATE_BIT = 7;
  localparam int CSPR_PWR_AUTO_BIT = 5;
  localparam int CSPR_PWR_VCC_CONNECT_BIT = 4;
  localparam int CSPR_PWR_VCC_MSB = 4;
  localparam int CSPR_PWR_VCC_LSB = 3;
  localparam int CSPR_PWR_VPP_MSB = 1;
  localparam int CSPR_PWR_VPP_LSB = 0;
  localparam logic [7:0] CSPR_PWR_MASK_LEGACY = 8'hB3;
  localparam logic [7:0] CSPR_PWR_MASK_EXT = 8'h9B;

  // Request field codes
  localparam logic [1:0] CSPR_VCC_5V = 2'h2;
  localparam logic [1:0] CSPR_VCC_3V3 = 2'h3;
  localparam logic [1:0] CSPR_VPP_REQ_NONE = 2'h0;
  localparam logic [1:0] CSPR_VPP_REQ_VCC = 2'h1;
  localparam logic [1:0] CSPR_VPP_REQ_12V = 2'h2;

  // Unmapped reads return this
  localparam logic [7:0] CSPR_RD_UNMAPPED = 8'h00;

  // Vpp switch selection driven to the power switch
  typedef enum logic [1:0] {
    CSPR_VPP_OFF = 2'h0,
    CSPR_VPP_VCC = 2'h1,
    CSPR_VPP_12V = 2'h2
  } cspr_vpp_t;

  // Live card interface pins, sampled on ref_clk
  typedef struct packed {
    logic ready;
    logic writeProtect;
    logic cd2N;
    logic cd1N;
    logic bvd2Spkr;
    logic bvd1Stschg;
  } cspr_pins_t;

  // Decoded socket power request
  typedef struct packed {
    logic cardOutputGate;
    logic vccOn;
    logic vcc3v3;
    cspr_vpp_t vpp;
  } cspr_power_t;

endpackage

// ---- cspr_power_decode.sv ----
// Decodes the stored power control byte into switch requests
`timescale 1ns/1ps
`default_nettype none

module cspr_power_decode (
  input wire logic [7:0] powerCtrl,
  input wire logic legacyLayout,
  input wire logic vccLevelSelect,
  input wire logic cd1N,
  input wire logic cd2N,
  output cspr_pkg::cspr_power_t power
);
  import cspr_pkg::*;

  // Layout dependent Vcc decode and Vcc-gated Vpp decode
  always_comb begin
    logic [1:0] vccField;
    logic [1:0] vppField;
    vccField = powerCtrl[CSPR_PWR_VCC_MSB:CSPR_PWR_VCC_LSB];
    vppField = powerCtrl[CSPR_PWR_VPP_MSB:CSPR_PWR_VPP_LSB];
    power.cardOutputGate = powerCtrl[CSPR_PWR_GATE_BIT];
    if (legacyLayout) begin
      power.vccOn = powerCtrl[CSPR_PWR_VCC_CONNECT_BIT] &
                    (~powerCtrl[CSPR_PWR_AUTO_BIT] | (~cd1N & ~cd2N));
      power.vcc3v3 = vccLevelSelect;
    end else begin
      power.vccOn = (vccField == CSPR_VCC_5V) || (vccField == CSPR_VCC_3V3);
      power.vcc3v3 = (vccField == CSPR_VCC_3V3);
    end
    if (!power.vccOn) begin
      power.vpp = CSPR_VPP_OFF;
    end else if (vppField == CSPR_VPP_REQ_VCC) begin
      power.vpp = CSPR_VPP_VCC;
    end else if (vppField == CSPR_VPP_REQ_12V) begin
      power.vpp = CSPR_VPP_12V;
    end else begin
      power.vpp = CSPR_VPP_OFF;
    end
  end

endmodule

`default_nettype wire

// ---- cspr_socket_regs.sv ----
// Socket interface status and power control registers with layout select
//
// Operation
// - Status bit 7 always reads zero.
// - Status bit 6 shows socket power on.
// - Status bit 5 follows card ready.
// - Status bit 4 follows write protect.
// - Status bit 3 is inverted second detect.
// - Status bit 2 is inverted first detect.
// - Memory card: bits 1:0 show battery state.
// - I/O card: bits 1:0 mirror speaker, change.
// - Status read-only; bits 7:6 zero after reset.
// - Power bit 7 gates card outputs.
// - Revision field picks legacy or extended layout.
// - Revision 0010 selects legacy layout.
// - Legacy bit 5 enables detect-driven switching.
// - Legacy bit 4 connects Vcc at level.
// - Legacy bits 6, 3:2 read zero.
// - Vpp field: none, Vcc, 12 V, reserved.
// - Vpp ignored while Vcc off.
// - Extended bits 4:3 select Vcc level.
// - Extended bits 6:5, 2 read zero.
`timescale 1ns/1ps
`default_nettype none

module cspr_socket_regs (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [11:0] regAddr,
  input wire logic regWr,
  input wire logic [7:0] regWrData,
  input wire logic regRd,
  output logic [7:0] regRdData,
  output logic regRdValid,
  input wire cspr_pkg::cspr_pins_t cardPins,
  input wire logic vccLevelSelect,
  output logic cardOutputGate,
  output logic vccEnable,
  output logic vcc3v3Select,
  output cspr_pkg::cspr_vpp_t vppSelect,
  output logic layoutLegacy
);
  import cspr_pkg::*;

  logic [7:0] idReg;
  logic [7:0] idNext;
  logic [7:0] powerReg;
  logic [7:0] powerNext;
  cspr_power_t powerStateReg;
  cspr_power_t powerStateNext;
  logic legacyReg;
  logic legacyNext;
  logic [7:0] rdDataReg;
  logic [7:0] rdDataNext;
  logic rdValidReg;
  logic rdValidNext;
  logic [7:0] powerMask;
  logic [7:0] statusByte;
  cspr_power_t powerDecoded;

  assign legacyNext = (idNext[3:0] == CSPR_REV_LEGACY);

  assign powerMask = legacyReg ? CSPR_PWR_MASK_LEGACY : CSPR_PWR_MASK_EXT;

  // Live status byte assembled from pins and power state
  always_comb begin
    statusByte = 8'h00;
    statusByte[CSPR_ST_RSVD_BIT] = 1'b0;
    statusByte[CSPR_ST_POWER_BIT] = powerStateReg.vccOn;
    statusByte[CSPR_ST_READY_BIT] = cardPins.ready;
    statusByte[CSPR_ST_WP_BIT] = cardPins.writeProtect;
    statusByte[CSPR_ST_CD2_BIT] = ~cardPins.cd2N;
    statusByte[CSPR_ST_CD1_BIT] = ~cardPins.cd1N;
    // same pins carry speaker and change
    statusByte[CSPR_ST_BVD2_BIT] = cardPins.bvd2Spkr;
    statusByte[CSPR_ST_BVD1_BIT] = cardPins.bvd1Stschg;
  end

  // Register writes; only writable bits are ever stored
  always_comb begin
    idNext = idReg;
    powerNext = powerReg;
    if (regWr) begin
      if (regAddr == CSPR_ADDR_ID) begin
        idNext = CSPR_ID_FIXED | (regWrData & CSPR_ID_WR_MASK);
      end else if (regAddr == CSPR_ADDR_POWER) begin
        powerNext = regWrData & powerMask;
      end
    end
    // A layout change clears bits that the new layout reserves; the new layout is
    // taken from idNext here so this process never reads its own result back
    if ((idNext[3:0] == CSPR_REV_LEGACY) != legacyReg) begin
      powerNext = powerNext & ((idNext[3:0] == CSPR_REV_LEGACY) ? CSPR_PWR_MASK_LEGACY : CSPR_PWR_MASK_EXT);
    end
  end

  // Read port: data latched on the request, one-cycle valid strobe
  always_comb begin
    rdDataNext = rdDataReg;
    rdValidNext = regRd;
    if (regRd) begin
      if (regAddr == CSPR_ADDR_ID) begin
        rdDataNext = idReg;
      end else if (regAddr == CSPR_ADDR_STATUS) begin
        rdDataNext = statusByte;
      end else if (regAddr == CSPR_ADDR_POWER) begin
        rdDataNext = powerReg & powerMask;
      end else begin
        rdDataNext = CSPR_RD_UNMAPPED;
      end
    end
  end

  // Power request decode
  cspr_power_decode uDecode (
    .powerCtrl(powerReg),
    .legacyLayout(legacyReg),
    .vccLevelSelect(vccLevelSelect),
    .cd1N(cardPins.cd1N),
    .cd2N(cardPins.cd2N),
    .power(powerDecoded)
  );

  assign powerStateNext = powerDecoded;

  // State registers
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      idReg <= CSPR_ID_RESET;
      powerReg <= CSPR_PWR_RESET;
      legacyReg <= 1'b0;
      // power off after reset so bit 6 reads zero
      powerStateReg <= '{cardOutputGate: 1'b0, vccOn: 1'b0, vcc3v3: 1'b0, vpp: CSPR_VPP_OFF};
      rdDataReg <= 8'h00;
      rdValidReg <= 1'b0;
    end else begin
      idReg <= idNext;
      powerReg <= powerNext;
      legacyReg <= legacyNext;
      powerStateReg <= powerStateNext;
      rdDataReg <= rdDataNext;
      rdValidReg <= rdValidNext;
    end
  end

  // Outputs straight from flip-flops
  assign regRdData = rdDataReg;
  assign regRdValid = rdValidReg;
  assign cardOutputGate = powerStateReg.cardOutputGate;
  assign vccEnable = powerStateReg.vccOn;
  assign vcc3v3Select = powerStateReg.vcc3v3;
  assign vppSelect = powerStateReg.vpp;
  assign layoutLegacy = legacyReg;

endmodule

`default_nettype wire

// ---- cspr_socket_regs_properties.sv ----
// Port assertions for the socket status and power registers
`timescale 1ns/1ps
`default_nettype none
module cspr_socket_regs_properties (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [11:0] regAddr,
  input wire logic regWr,
  input wire logic [7:0] regWrData,
  input wire logic regRd,
  input wire logic [7:0] regRdData,
  input wire logic regRdValid,
  input wire cspr_pkg::cspr_pins_t cardPins,
  input wire logic vccLevelSelect,
  input wire logic cardOutputGate,
  input wire logic vccEnable,
  input wire logic vcc3v3Select,
  input wire cspr_pkg::cspr_vpp_t vppSelect,
  input wire logic layoutLegacy
);
  import cspr_pkg::*;
  logic [7:0] expStatus;
  // Status byte the pins and power state should give
  assign expStatus = {1'b0, vccEnable, cardPins.ready, cardPins.writeProtect, ~cardPins.cd2N, ~cardPins.cd1N,
    cardPins.bvd2Spkr, cardPins.bvd1Stschg};
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  chk_rd_valid: assert property (regRdValid == $past(regRd)) else $error("read valid timing");
  chk_rd_hold: assert property (!regRd |=> $stable(regRdData)) else $error("read data moved");
  chk_status_read: assert property ((regRd && regAddr == CSPR_ADDR_STATUS) |=>
    regRdData == $past(expStatus)) else $error("status byte wrong");
  chk_gate_follow: assert property ((regWr && regAddr == CSPR_ADDR_POWER) |=> ##1
    cardOutputGate == $past(regWrData[7], 2)) else $error("output gate wrong");
  chk_vpp_gated: assert property (!vccEnable |-> vppSelect == CSPR_VPP_OFF) else $error("vpp without vcc");
  chk_layout_sel: assert property ((regWr && regAddr == CSPR_ADDR_ID) |=>
    layoutLegacy == ($past(regWrData[3:0]) == CSPR_REV_LEGACY)) else $error("layout select wrong");
  chk_ext_vcc: assert property ((regWr && regAddr == CSPR_ADDR_POWER && !layoutLegacy) ##1 !regWr |=>
    vccEnable == $past(regWrData[4], 2) && (!vccEnable || vcc3v3Select == $past(regWrData[3], 2)))
    else $error("extended vcc wrong");
  chk_legacy_vcc: assert property ((regWr && regAddr == CSPR_ADDR_POWER && layoutLegacy && !regWrData[5]) ##1 !regWr
    |=> vccEnable == $past(regWrData[4], 2) && (!vccEnable || vcc3v3Select == $past(vccLevelSelect)))
    else $error("legacy vcc wrong");
  // Main scenarios reached
  cover property (regRd && regAddr == CSPR_ADDR_STATUS);
  cover property (layoutLegacy && vccEnable);
  cover property (vppSelect == CSPR_VPP_12V);
endmodule
bind cspr_socket_regs cspr_socket_regs_properties i_cspr_socket_regs_properties (.ref_clk, .reset, .regAddr,
  .regWr, .regWrData, .regRd, .regRdData, .regRdValid, .cardPins, .vccLevelSelect, .cardOutputGate, .vccEnable,
  .vcc3v3Select, .vppSelect, .layoutLegacy);
`default_nettype wire

// ---- cspr_card_model.sv ----
// Behavioural card in the socket driving the interface pins
`timescale 1ns/1ps
`default_nettype none
module cspr_card_model (
  input wire logic ref_clk,
  input wire logic present,
  input wire logic [5:0] lines,
  output var cspr_pkg::cspr_pins_t cardPins
);
  import cspr_pkg::*;
  // Empty socket lets every line float to its pull-up
  always @(negedge ref_clk) begin
    cardPins <= present ? lines : 6'h3F;
  end
endmodule
`default_nettype wire

// ---- test_card_socket_status_power_regs.sv ----
// Self-checking bench for the socket status and power registers
`timescale 1ns/1ps
`default_nettype none
module test_card_socket_status_power_regs;
  import cspr_pkg::*;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [11:0] regAddr = 12'h000;
  logic regWr = 1'b0;
  logic [7:0] regWrData = 8'h00;
  logic regRd = 1'b0;
  logic vccLevelSelect = 1'b0;
  logic present = 1'b0;
  logic [5:0] lines = 6'h00;
  logic [7:0] regRdData;
  logic regRdValid, cardOutputGate, vccEnable, vcc3v3Select, layoutLegacy;
  cspr_pins_t cardPins;
  cspr_vpp_t vppSelect;
  int fails = 0;
  int checks_done = 0;
  int seed = 32'hC1ABD204;
  logic [31:0] r;
  logic [7:0] pwrReg = 8'h00;
  logic legacy = 1'b0;
  logic [11:0] addrs [4] = '{12'h800, 12'h802, 12'h802, 12'h801};
  logic [19:0] corner [10] = '{20'h80002, 20'h802FF, 20'h801FF, 20'h80213, 20'h80034, 20'h802FF, 20'h80203,
    20'h80292, 20'h8029B, 20'h80355};
  always #2.5 ref_clk = ~ref_clk;
  cspr_card_model i_cspr_card_model (.ref_clk, .present, .lines, .cardPins);
  cspr_socket_regs i_cspr_socket_regs (.ref_clk, .reset, .regAddr, .regWr, .regWrData, .regRd, .regRdData,
    .regRdValid, .cardPins, .vccLevelSelect, .cardOutputGate, .vccEnable, .vcc3v3Select, .vppSelect, .layoutLegacy);
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [7:0] msk(input logic l);
    return l ? CSPR_PWR_MASK_LEGACY : CSPR_PWR_MASK_EXT;
  endfunction
  // Expected Vcc: extended by field, legacy by enable and detects
  function automatic logic vccOn();
    return pwrReg[4] & (!legacy | !pwrReg[5] | (!cardPins.cd1N & !cardPins.cd2N));
  endfunction
  // Write one byte and keep the expected register image
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    regAddr = a;
    regWrData = d;
    regWr = 1'b1;
    @(negedge ref_clk);
    regWr = 1'b0;
    if (a == CSPR_ADDR_ID) legacy = (d[3:0] == CSPR_REV_LEGACY);
    if (a == CSPR_ADDR_POWER) pwrReg = d;
    pwrReg = pwrReg & msk(legacy);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    @(negedge ref_clk);
    regAddr = a;
    regRd = 1'b1;
    @(negedge ref_clk);
    regRd = 1'b0;
    check({7'h00, regRdValid}, 8'h01);
    check(regRdData, exp);
  endtask
  task automatic verify();
    logic v;
    repeat (3) @(negedge ref_clk);
    v = vccOn();
    check({7'h00, cardOutputGate}, {7'h00, pwrReg[7]});
    check({5'h00, vccEnable, vppSelect}, {5'h00, v, (v && pwrReg[1:0] != 2'h3) ? pwrReg[1:0] : 2'h0});
    check({7'h00, vcc3v3Select & v}, {7'h00, v & (legacy ? vccLevelSelect : pwrReg[3])});
    check({7'h00, layoutLegacy}, {7'h00, legacy});
    rd(CSPR_ADDR_STATUS, {1'b0, v, cardPins[5:4], ~cardPins[3:2], cardPins[1:0]});
    rd(CSPR_ADDR_POWER, pwrReg);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Watchdog: whole run needs a few microseconds
  initial begin
    #50000;
    fails++;
    print_verdict();
  end
  initial begin
    repeat (20) @(negedge ref_clk);
    reset = 1'b0;
    verify();
    rd(12'h803, CSPR_RD_UNMAPPED);
    $display("reset value test done");
    // Corner cases: both layouts, full masks, status write, reserved Vpp code with Vcc off
    lines = 6'h30;
    foreach (corner[i]) begin
      present = i[0];
      wr(corner[i][19:8], corner[i][7:0]);
      verify();
    end
    rd(CSPR_ADDR_ID, CSPR_ID_FIXED | (8'h34 & CSPR_ID_WR_MASK));
    $display("corner test done");
    repeat (40) begin
      r = $random(seed);
      {present, lines, vccLevelSelect} = r[18:11];
      wr(addrs[r[9:8]], r[10] ? {r[7:4], CSPR_REV_LEGACY} : r[7:0]);
      verify();
    end
    $display("random test done");
    reset = 1'b1;
    repeat (2) @(negedge ref_clk);
    reset = 1'b0;
    pwrReg = 8'h00;
    legacy = 1'b0;
    verify();
    rd(CSPR_ADDR_ID, CSPR_ID_RESET);
    $display("reset test done");
    print_verdict();
  end
endmodule
`default_nettype wire
